/* design/tx_framer_regs.svh */
`ifndef TX_FRAMER_REGS_SVH
`define TX_FRAMER_REGS_SVH

// ----------------------------------------
// Register byte offsets on the APB slave
// ----------------------------------------
`define TXF_OFS_CTRL_ONE 8'h00
`define TXF_OFS_CTRL_TWO 8'h04
`define TXF_OFS_PORT_TWO 8'h08
`define TXF_OFS_DATA 8'h0C
`define TXF_OFS_STATUS 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TXF_FRLEN_HI 14
`define TXF_FRLEN_LO 8
`define TXF_WDLEN_HI 7
`define TXF_WDLEN_LO 5
`define TXF_PHASE_BIT 15
`define TXF_IGNORE_BIT 2
`define TXF_ENABLE_BIT 0
`define TXF_SYNCERR_BIT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TXF_FRLEN_RST 7'h00
`define TXF_WDLEN_RST 3'h0

// ----------------------------------------
// Data path sizing
// ----------------------------------------
`define TXF_FIFO_DEPTH 8
`define TXF_WORD_W 32

`endif

/* design/tx_framer_pkg.sv */
package tx_framer_pkg;
  // Bus address and data types
  typedef logic [7:0] addr_t;
  typedef logic [31:0] word_t;
  // Link-side shifter states
  typedef enum logic {
    ST_IDLE,
    ST_SHIFT
  } link_state_t;
endpackage

/* design/stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Valid/ready word stream between the framer and its FIFO
interface stream_if #(parameter int W = 32);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* design/tx_word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Transmit word FIFO, first-word fall-through
// ----------------------------------------
module tx_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  stream_if.snk wr_s,
  stream_if.src rd_s
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Word storage
  logic [AW-1:0] wptr_q, wptr_d;  // Write pointer
  logic [AW-1:0] rptr_q, rptr_d;  // Read pointer
  logic [CW-1:0] cnt_q, cnt_d;    // Fill level
  logic push;
  logic pop;

  // Honest flags: ready only with a free slot, valid only with data
  assign wr_s.ready = (cnt_q != FULL_CNT);
  assign rd_s.valid = (cnt_q != '0);
  assign rd_s.data = mem[rptr_q];

  // Next pointers; wrap relies on a power-of-two depth
  always_comb begin
    push = wr_s.valid & wr_s.ready;
    pop = rd_s.valid & rd_s.ready;
    wptr_d = push ? wptr_q + AW'(1) : wptr_q;
    rptr_d = pop ? rptr_q + AW'(1) : rptr_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  // Registers and storage write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem[wptr_q] <= wr_s.data;
    end
  end
endmodule
`default_nettype wire

/* design/tx_framer.sv */
// Operation
// - Single phase uses phase-one word length always
// - Dual phase: each phase its own length
// - Seven-bit length field, sends value plus one
// - Single phase: total equals phase-one count
// - Dual phase: total is both counts summed
// - Phase-two length used only when dual
// - Both length fields reset to zero
// - Total length is words per frame sync
// - Sync before frame end counts as unexpected
// - Ignore set: unexpected sync has no effect
// - Ignore clear: abort, flag error, resend word
// - Phase-count bit fifteen selects one or two
`timescale 1ns/1ps
`default_nettype none
`include "tx_framer_regs.svh"
module tx_framer (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tx_framer_pkg::addr_t paddr,
  input wire tx_framer_pkg::word_t pwdata,
  output var tx_framer_pkg::word_t prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic tx_bit_clk,
  input wire logic tx_frame_sync,
  output var logic tx_data
);
  import tx_framer_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Word length code to bit count; reserved codes fall back to 8
  function automatic logic [5:0] word_bits(input logic [2:0] code);
    unique case (code)
      3'h0: word_bits = 6'h08;
      3'h1: word_bits = 6'h0C;
      3'h2: word_bits = 6'h10;
      3'h3: word_bits = 6'h14;
      3'h4: word_bits = 6'h18;
      3'h5: word_bits = 6'h20;
      default: word_bits = 6'h08;
    endcase
  endfunction

  // Words per frame; nine bits since two full phases make 256
  function automatic logic [8:0] frame_total(input logic dual,
                                             input logic [6:0] l1,
                                             input logic [6:0] l2);
    logic [8:0] p1;
    logic [8:0] p2;
    p1 = {2'b00, l1} + 9'h001;
    p2 = {2'b00, l2} + 9'h001;
    frame_total = dual ? p1 + p2 : p1;
  endfunction

  // Left-align a word so its MSB leaves first
  function automatic word_t align(input word_t w, input logic [5:0] bits);
    align = w << (6'h20 - bits);
  endfunction

  // ----------------------------------------
  // Control register state
  // ----------------------------------------
  logic [6:0] len1_q, len1_d;     // Phase-one words minus one
  logic [2:0] wlen1_q, wlen1_d;   // Phase-one word length code
  logic [6:0] len2_q, len2_d;     // Phase-two words minus one
  logic [2:0] wlen2_q, wlen2_d;   // Phase-two word length code
  logic dual_q, dual_d;           // Phase count select
  logic ignore_q, ignore_d;       // Sync ignore
  logic enable_q, enable_d;       // Transmitter running
  logic sync_err_q, sync_err_d;   // Sticky sync error flag
  word_t prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  // ----------------------------------------
  // Link state
  // ----------------------------------------
  logic bclk_m_q, bclk_s_q, bclk_p_q;  // Bit clock synchroniser and history
  logic fs_m_q, fs_s_q;                 // Frame sync synchroniser
  logic fs_prev_q, fs_prev_d;           // Sync level at previous bit rise
  link_state_t st_q, st_d;
  word_t word_q, word_d;                // Word kept for a resend
  word_t shreg_q, shreg_d;              // Outgoing shifter
  logic [5:0] left_q, left_d;           // Bits left in this word
  logic [8:0] cnt_q, cnt_d;             // Words done in this frame
  logic phase_q, phase_d;               // Current phase, 1 is phase two
  logic data_q, data_d;                 // Serial data pin register

  // Cross-group strobes
  logic err_set;   // Unexpected sync seen, flag to be raised
  logic pop;       // Take a word from the FIFO
  logic access;
  logic data_wr;
  logic done;
  logic mapped;
  word_t rd;

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  stream_if #(.W(`TXF_WORD_W)) push_s ();
  stream_if #(.W(`TXF_WORD_W)) pop_s ();

  tx_word_fifo #(
    .WIDTH(`TXF_WORD_W),
    .DEPTH(`TXF_FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rstn(rstn),
    .wr_s(push_s),
    .rd_s(pop_s)
  );

  assign push_s.data = pwdata;
  assign push_s.valid = data_wr;
  assign pop_s.ready = pop;

  // ----------------------------------------
  // APB slave and register file
  // ----------------------------------------
  // Next values for registers and bus answer
  always_comb begin
    access = psel & penable & ~pready_q;
    data_wr = access & pwrite & (paddr == `TXF_OFS_DATA);
    // A data write waits while the FIFO is full: that is the stall
    done = access & (~data_wr | push_s.ready);
    mapped = (paddr == `TXF_OFS_CTRL_ONE) || (paddr == `TXF_OFS_CTRL_TWO)
          || (paddr == `TXF_OFS_PORT_TWO) || (paddr == `TXF_OFS_DATA)
          || (paddr == `TXF_OFS_STATUS);
    len1_d = len1_q;
    wlen1_d = wlen1_q;
    len2_d = len2_q;
    wlen2_d = wlen2_q;
    dual_d = dual_q;
    ignore_d = ignore_q;
    enable_d = enable_q;
    sync_err_d = sync_err_q;
    pready_d = done;
    pslverr_d = done & ~mapped;
    prdata_d = 32'h0000_0000;
    // Read view; unused bits stay zero
    rd = 32'h0000_0000;
    unique case (paddr)
      `TXF_OFS_CTRL_ONE: begin
        rd[`TXF_FRLEN_HI:`TXF_FRLEN_LO] = len1_q;
        rd[`TXF_WDLEN_HI:`TXF_WDLEN_LO] = wlen1_q;
      end
      `TXF_OFS_CTRL_TWO: begin
        rd[`TXF_PHASE_BIT] = dual_q;
        rd[`TXF_FRLEN_HI:`TXF_FRLEN_LO] = len2_q;
        rd[`TXF_WDLEN_HI:`TXF_WDLEN_LO] = wlen2_q;
        rd[`TXF_IGNORE_BIT] = ignore_q;
      end
      `TXF_OFS_PORT_TWO: begin
        rd[`TXF_SYNCERR_BIT] = sync_err_q;
        rd[`TXF_ENABLE_BIT] = enable_q;
      end
      `TXF_OFS_STATUS: begin
        // Frame progress seen by software
        rd[8:0] = cnt_q;
        rd[16] = phase_q;
        rd[17] = (st_q == ST_SHIFT);
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase
    if (done && !pwrite) begin
      prdata_d = rd;
    end
    // Register writes
    if (done && pwrite) begin
      unique case (paddr)
        `TXF_OFS_CTRL_ONE: begin
          len1_d = pwdata[`TXF_FRLEN_HI:`TXF_FRLEN_LO];
          wlen1_d = pwdata[`TXF_WDLEN_HI:`TXF_WDLEN_LO];
        end
        `TXF_OFS_CTRL_TWO: begin
          dual_d = pwdata[`TXF_PHASE_BIT];
          len2_d = pwdata[`TXF_FRLEN_HI:`TXF_FRLEN_LO];
          wlen2_d = pwdata[`TXF_WDLEN_HI:`TXF_WDLEN_LO];
          ignore_d = pwdata[`TXF_IGNORE_BIT];
        end
        `TXF_OFS_PORT_TWO: begin
          enable_d = pwdata[`TXF_ENABLE_BIT];
          // Write one clears the flag
          if (pwdata[`TXF_SYNCERR_BIT]) begin
            sync_err_d = 1'b0;
          end
        end
        default: begin
          enable_d = enable_q;
        end
      endcase
    end
    // Hardware set beats a clear in the same cycle
    if (err_set) begin
      sync_err_d = 1'b1;
    end
  end

  // Register the control group
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      len1_q <= `TXF_FRLEN_RST;
      wlen1_q <= `TXF_WDLEN_RST;
      len2_q <= `TXF_FRLEN_RST;
      wlen2_q <= `TXF_WDLEN_RST;
      dual_q <= 1'b0;
      ignore_q <= 1'b0;
      enable_q <= 1'b0;
      sync_err_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      len1_q <= len1_d;
      wlen1_q <= wlen1_d;
      len2_q <= len2_d;
      wlen2_q <= wlen2_d;
      dual_q <= dual_d;
      ignore_q <= ignore_d;
      enable_q <= enable_d;
      sync_err_q <= sync_err_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_data = data_q;

  // ----------------------------------------
  // Link framing and shifter
  // ----------------------------------------
  logic bclk_rise;
  logic bclk_fall;
  logic fs_start;
  logic in_frame;
  logic next_phase;
  logic [8:0] cnt_next;
  logic [5:0] bits_next;
  word_t fetched;

  // Next values for the shifter; bit clock edges come from synced copies
  always_comb begin
    bclk_rise = bclk_s_q & ~bclk_p_q;
    bclk_fall = ~bclk_s_q & bclk_p_q;
    fs_start = bclk_rise & fs_s_q & ~fs_prev_q;
    in_frame = (st_q == ST_SHIFT);
    // An empty FIFO sends zeros rather than stalling the link
    fetched = pop_s.valid ? pop_s.data : 32'h0000_0000;
    cnt_next = cnt_q + 9'h001;
    next_phase = dual_q & (phase_q | (cnt_next == {2'b00, len1_q} + 9'h001));
    bits_next = word_bits(next_phase ? wlen2_q : wlen1_q);
    fs_prev_d = bclk_rise ? fs_s_q : fs_prev_q;
    st_d = st_q;
    word_d = word_q;
    shreg_d = shreg_q;
    left_d = left_q;
    cnt_d = cnt_q;
    phase_d = phase_q;
    data_d = data_q;
    err_set = 1'b0;
    pop = 1'b0;
    if (!enable_q) begin
      // Stopped transmitter holds the line low
      st_d = ST_IDLE;
      data_d = 1'b0;
      cnt_d = 9'h000;
      phase_d = 1'b0;
    end else if (fs_start && !in_frame) begin
      // Expected sync: new frame, first word from the FIFO
      pop = 1'b1;
      word_d = fetched;
      shreg_d = align(fetched, word_bits(wlen1_q));
      left_d = word_bits(wlen1_q);
      cnt_d = 9'h000;
      phase_d = 1'b0;
      st_d = ST_SHIFT;
    end else if (fs_start && in_frame) begin
      if (!ignore_q) begin
        // Abort: the held word restarts as slot zero of a fresh frame
        err_set = 1'b1;
        shreg_d = align(word_q, word_bits(wlen1_q));
        left_d = word_bits(wlen1_q);
        cnt_d = 9'h000;
        phase_d = 1'b0;
      end
      // Otherwise the pulse is simply dropped
    end else if (bclk_fall && in_frame) begin
      // Drive the next bit on the falling edge, MSB first
      data_d = shreg_q[31];
      shreg_d = {shreg_q[30:0], 1'b0};
      left_d = left_q - 6'h01;
      if (left_q == 6'h01) begin
        cnt_d = cnt_next;
        if (cnt_next == frame_total(dual_q, len1_q, len2_q)) begin
          st_d = ST_IDLE;
        end else begin
          pop = 1'b1;
          word_d = fetched;
          shreg_d = align(fetched, bits_next);
          left_d = bits_next;
          phase_d = next_phase;
        end
      end
    end
  end

  // Register the link group; first sync stages feed only the second
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bclk_m_q <= 1'b0;
      bclk_s_q <= 1'b0;
      bclk_p_q <= 1'b0;
      fs_m_q <= 1'b0;
      fs_s_q <= 1'b0;
      fs_prev_q <= 1'b0;
      st_q <= ST_IDLE;
      word_q <= 32'h0000_0000;
      shreg_q <= 32'h0000_0000;
      left_q <= 6'h00;
      cnt_q <= 9'h000;
      phase_q <= 1'b0;
      data_q <= 1'b0;
    end else begin
      bclk_m_q <= tx_bit_clk;
      bclk_s_q <= bclk_m_q;
      bclk_p_q <= bclk_s_q;
      fs_m_q <= tx_frame_sync;
      fs_s_q <= fs_m_q;
      fs_prev_q <= fs_prev_d;
      st_q <= st_d;
      word_q <= word_d;
      shreg_q <= shreg_d;
      left_q <= left_d;
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      data_q <= data_d;
    end
  end
endmodule
`default_nettype wire

/* verif/tx_framer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checks on the framer
// ----------------------------------------
module tx_framer_asserts (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tx_framer_pkg::addr_t paddr,
  input wire tx_framer_pkg::word_t pwdata,
  input wire tx_framer_pkg::word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_bit_clk,
  input wire logic tx_frame_sync,
  input wire logic tx_data
);
  import tx_framer_pkg::*;
  // Aligned word offsets up to the status word
  logic mapped;
  assign mapped = (paddr <= 8'h10) && (paddr[1:0] == 2'b00);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Data writes may stall on a full buffer, so they are left out
  ans_next_a: assert property ($rose(penable) && psel && paddr != 8'h0C |=> pready)
    else $error("access not answered next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_unmapped_a: assert property (pready && psel && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (pready && psel && mapped |-> !pslverr)
    else $error("mapped access refused");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  // Bits launch from a falling bit clock edge only
  data_fall_a: assert property ($changed(tx_data) |-> !tx_bit_clk)
    else $error("serial data moved while clock high");
endmodule
`default_nettype wire

/* verif/serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial peer: bit clock, sync, capture
// ----------------------------------------
module serial_peer (
  input wire logic core_clk,
  input wire logic tx_data,
  output var logic tx_bit_clk,
  output var logic tx_frame_sync,
  output var logic bit_seen,
  output var logic bit_val
);
  // Clock idles low between frames
  initial begin
    tx_bit_clk = 1'b0;
    tx_frame_sync = 1'b0;
    bit_seen = 1'b0;
    bit_val = 1'b0;
  end
  task automatic half(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One frame of nrise sampled bits; sync_at raises an early sync
  task automatic run(input int nrise, input int sync_at);
    @(posedge core_clk) tx_frame_sync <= 1'b1;
    half(8);
    tx_bit_clk <= 1'b1;
    for (int i = 1; i <= nrise; i++) begin
      half(8);
      tx_bit_clk <= 1'b0;
      tx_frame_sync <= 1'b0;
      half(4);
      tx_frame_sync <= (i == sync_at);
      half(4);
      // Sample on the rise, half a bit after launch
      tx_bit_clk <= 1'b1;
      bit_val <= tx_data;
      bit_seen <= 1'b1;
      half(1);
      bit_seen <= 1'b0;
    end
    half(8);
    tx_bit_clk <= 1'b0;
    tx_frame_sync <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/serial_tx_frame_length_sync_ignore_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_tx_frame_length_sync_ignore_bench;
  import tx_framer_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  addr_t paddr = 8'h00;
  word_t pwdata = 32'h0000_0000;
  word_t prdata;
  logic pready, pslverr, tx_bit_clk, tx_frame_sync, tx_data, bit_seen, bit_val;
  int err_total = 0;
  int check_count = 0;
  integer seed = 32'hf034_23fe;
  int lens[8] = '{8, 12, 16, 20, 24, 32, 8, 8};
  logic exp_bits[$];
  logic [32:0] exp_rd[$];
  word_t w;

  always #2.5 core_clk = ~core_clk;

  tx_framer i_dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_bit_clk, .tx_frame_sync, .tx_data);
  serial_peer i_peer (.core_clk, .tx_data, .tx_bit_clk, .tx_frame_sync, .bit_seen,
    .bit_val);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Request held until the edge that samples ready
  task automatic apb(input logic wr, input addr_t a, input word_t d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input addr_t a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic push(input word_t v, input int hi, input int lo);
    for (int i = hi; i >= lo; i--) exp_bits.push_back(v[i]);
  endtask
  // Random words, expected MSB first from the low n bits
  task automatic send(input int n, input int cnt);
    repeat (cnt) begin
      w = $random(seed);
      apb(1'b1, 8'h0C, w);
      push(w, n - 1, 0);
    end
  endtask

  // Watcher: each result takes the oldest note
  always @(posedge core_clk) begin
    if (bit_seen) check("tx_data", {32'h0000_0000, exp_bits.pop_front()}, {32'h0000_0000, bit_val});
    if (psel && penable && pready && !pwrite) check("prdata", exp_rd.pop_front(), {pslverr, prdata});
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    rd(8'h00, 33'h0_0000_0000);
    rd(8'h04, 33'h0_0000_0000);
    rd(8'h14, 33'h1_0000_0000);
    apb(1'b1, 8'h08, 32'h0000_0001);
    // Longest phase; buffer fills, ninth write waits for a pop
    apb(1'b1, 8'h00, 32'h0000_7F00);
    send(8, 8);
    fork
      begin
        send(8, 1);
        repeat (952) exp_bits.push_back(1'b0);
      end
      i_peer.run(1024, 0);
    join
    // Single phase; phase-two settings must not matter
    apb(1'b1, 8'h00, 32'h0000_0200);
    apb(1'b1, 8'h04, 32'h0000_05A0);
    send(8, 3);
    i_peer.run(24, 0);
    apb(1'b1, 8'h00, 32'h0000_0120);
    apb(1'b1, 8'h04, 32'h0000_8040);
    send(12, 2);
    send(16, 1);
    i_peer.run(40, 0);
    // Status after the frame: three words done, phase two, not busy
    rd(8'h10, 33'h0_0001_0003);
    rd(8'h08, 33'h0_0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0004);
    // Every length code, one word per frame
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 8'h00, 32'(k) << 5);
      send(lens[k], 1);
      i_peer.run(lens[k], (k == 0) ? 4 : 0);
    end
    rd(8'h08, 33'h0_0000_0001);
    // Early sync mid second word: abort and resend it
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0100);
    send(8, 1);
    w = $random(seed);
    apb(1'b1, 8'h0C, w);
    push(w, 7, 4);
    push(w, 7, 0);
    send(8, 1);
    i_peer.run(28, 12);
    // Restarted frame still ends after its two words
    rd(8'h10, 33'h0_0000_0002);
    rd(8'h08, 33'h0_0000_0009);
    apb(1'b1, 8'h08, 32'h0000_0009);
    rd(8'h08, 33'h0_0000_0001);
    give_verdict;
  end

  // Watchdog about twice the expected run length of some 22k cycles
  initial begin
    #250000;
    err_total++;
    give_verdict;
  end
endmodule

bind tx_framer tx_framer_asserts i_chk (.core_clk(core_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_bit_clk(tx_bit_clk),
  .tx_frame_sync(tx_frame_sync), .tx_data(tx_data));
`default_nettype wire
